/* File: hw/mmuc_pkg.sv */
package mmuc_pkg;

    // System clock fc
    localparam int CLK_HZ = 20_000_000;

    // Word index of each register; byte address is four times the index
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_MATCH_LO = 3'h1;
    localparam logic [2:0] REG_MATCH_HI = 3'h2;
    localparam logic [2:0] REG_CAP_LO = 3'h3;
    localparam logic [2:0] REG_CAP_HI = 3'h4;
    localparam logic [2:0] REG_CNT_LO = 3'h5;
    localparam logic [2:0] REG_CNT_HI = 3'h6;
    localparam logic [2:0] REG_STATUS = 3'h7;

    // Reset values
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [15:0] MATCH_RST = 16'hffff;
    localparam logic [15:0] CAP_RST = 16'h0000;

    // Start control field codes
    localparam logic [1:0] START_STOP = 2'h0;
    localparam logic [1:0] START_CMD = 2'h1;
    localparam logic [1:0] START_RISE = 2'h2;
    localparam logic [1:0] START_FALL = 2'h3;

    // Operating mode field codes
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_WINDOW = 2'h1;

    // Source clock select codes
    localparam logic [1:0] CLK_DIV11 = 2'h0;
    localparam logic [1:0] CLK_DIV7 = 2'h1;
    localparam logic [1:0] CLK_DIV3 = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;

    // Pin filter figures, in fc periods
    localparam int FILT_REJECT_FC = 4;
    localparam int FILT_DETECT_FC = 12;
    localparam int FILT_CYC = (FILT_REJECT_FC + FILT_DETECT_FC) / 2;

    // Counter control register, bit 6 down to bit 0
    typedef struct packed {
        logic option;
        logic [1:0] start;
        logic [1:0] clk_sel;
        logic [1:0] mode;
    } mmuc_ctrl_t;

    typedef enum logic [2:0] {
        M_OFF,
        M_TIMER,
        M_TRIG,
        M_EVENT,
        M_WINDOW
    } mmuc_mode_t;

endpackage

/* File: hw/mmuc_top.sv */
`timescale 1ns/1ps
module mmuc_top
    import mmuc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic CLK_IN, // System clock fc
    input wire logic RST_N_IN, // Async reset, active low
    input wire logic [2:0] AVS_ADDRESS_IN, // Word address
    input wire logic AVS_READ_IN, // Read request
    input wire logic AVS_WRITE_IN, // Write request
    input wire logic [31:0] AVS_WRITEDATA_IN, // Write data
    input wire logic [3:0] AVS_BYTEENABLE_IN, // Byte lanes
    output logic [31:0] AVS_READDATA_OUT, // Read data
    output logic AVS_WAITREQUEST_OUT, // Stall
    input wire logic COUNTER_INPUT_PIN_IN, // External pulse pin
    input wire logic LOW_SPEED_IN, // Slow or sleep mode
    input wire logic STOP_ENTRY_IN, // Stop mode entry pulse
    output logic MATCH_IRQ_OUT // Match interrupt pulse
);

    ////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchroniser and noise filter

    localparam logic [3:0] FILT_MAX = 4'(FILT_CYC - 1);

    logic pin_meta_q;
    logic pin_sync_q;
    logic pin_filt_q;
    logic pin_prev_q;
    logic [3:0] filt_cnt_q;
    logic [3:0] filt_cnt_d;
    logic pin_filt_d;
    logic pin_differs;

    assign pin_differs = pin_sync_q != pin_filt_q;
    // Needs FILT_CYC steady cycles unless LOW_SPEED_IN bypasses it, which lets short glitches reach the counter
    assign filt_cnt_d = pin_differs ? filt_cnt_q + 4'h1 : 4'h0;
    assign pin_filt_d = LOW_SPEED_IN ? pin_sync_q :
        ((pin_differs && filt_cnt_q == FILT_MAX) ? pin_sync_q : pin_filt_q);

    always_ff @(posedge CLK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_filt_q <= 1'b0;
            pin_prev_q <= 1'b0;
            filt_cnt_q <= 4'h0;
        end else begin
            pin_meta_q <= COUNTER_INPUT_PIN_IN;
            pin_sync_q <= pin_meta_q;
            pin_filt_q <= pin_filt_d;
            pin_prev_q <= pin_filt_q;
            filt_cnt_q <= (LOW_SPEED_IN || pin_filt_d != pin_filt_q) ? 4'h0 : filt_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Prescaler

    logic [10:0] presc_q;

    function automatic logic div_tick(input logic [10:0] p, input logic [1:0] sel);
        logic t;
        t = 1'b0;
        unique case (sel)
            CLK_DIV11: t = &p[10:0];
            CLK_DIV7: t = &p[6:0];
            CLK_DIV3: t = &p[2:0];
            CLK_EXT: t = 1'b0;
        endcase
        return t;
    endfunction

    always_ff @(posedge CLK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            presc_q <= 11'h000;
        end else begin
            presc_q <= presc_q + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mode decode

    mmuc_ctrl_t ctrl_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] match_q;
    logic [CNT_W-1:0] cap_q;
    logic run_q;
    logic run_d;
    logic hit;

    mmuc_mode_t mode;
    wire pin_rise = pin_filt_q & ~pin_prev_q;
    wire pin_fall = ~pin_filt_q & pin_prev_q;
    wire ext_clk = ctrl_q.clk_sel == CLK_EXT;
    wire edge_pol = ctrl_q.start == START_RISE;
    wire cnt_edge = edge_pol ? pin_rise : pin_fall;
    wire opp_edge = edge_pol ? pin_fall : pin_rise;
    wire int_tick = div_tick(presc_q, ctrl_q.clk_sel);
    wire src_tick = ext_clk ? cnt_edge : int_tick;
    wire gate = edge_pol ? pin_filt_q : ~pin_filt_q;
    wire at_match = cnt_q == match_q;
    wire started = ctrl_q.start != START_STOP;
    wire edge_start = ctrl_q.start[1];

    assign mode = !started ? M_OFF :
        (ctrl_q.mode == MODE_WINDOW && edge_start && !ext_clk) ? M_WINDOW :
        (ctrl_q.mode != MODE_TIMER) ? M_OFF :
        (ctrl_q.start == START_CMD) ? (ext_clk ? M_OFF : M_TIMER) :
        ext_clk ? M_EVENT : M_TRIG;

    // Capture copies only where auto-capture exists
    wire auto_cap = ctrl_q.option && src_tick &&
        (mode == M_TIMER || mode == M_EVENT || mode == M_WINDOW);

    ////////////////////////////////////////////////////////////////////
    // Counter

    always_comb begin
        cnt_d = cnt_q;
        run_d = 1'b0;
        hit = 1'b0;
        unique case (mode)
            M_OFF: begin
                cnt_d = '0;
            end
            M_TIMER: begin
                if (int_tick) begin
                    if (at_match) begin
                        cnt_d = '0;
                        hit = 1'b1;
                    end else begin
                        cnt_d = cnt_q + CNT_W'(1);
                    end
                end
            end
            M_EVENT: begin
                if (cnt_edge) begin
                    cnt_d = cnt_q + CNT_W'(1);
                end else if (opp_edge && at_match) begin
                    cnt_d = '0;
                    hit = 1'b1;
                end
            end
            M_TRIG: begin
                run_d = run_q;
                if (!run_q) begin
                    if (cnt_edge) begin
                        run_d = 1'b1;
                        cnt_d = '0;
                    end
                end else if (opp_edge && ctrl_q.option) begin
                    run_d = 1'b0;
                    cnt_d = '0;
                end else if (int_tick) begin
                    if (at_match) begin
                        run_d = 1'b0;
                        cnt_d = '0;
                        hit = 1'b1;
                    end else begin
                        cnt_d = cnt_q + CNT_W'(1);
                    end
                end
            end
            M_WINDOW: begin
                if (int_tick && gate) begin
                    if (at_match) begin
                        cnt_d = '0;
                        hit = 1'b1;
                    end else begin
                        cnt_d = cnt_q + CNT_W'(1);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            MATCH_IRQ_OUT <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            MATCH_IRQ_OUT <= hit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, then the request is taken

    logic ack_q;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic wr_fire;

    assign wr_fire = AVS_WRITE_IN && ack_q && AVS_BYTEENABLE_IN[0];
    assign wbyte = AVS_WRITEDATA_IN[7:0];
    wire wr_ctrl = wr_fire && AVS_ADDRESS_IN == REG_CTRL;
    wire wr_m_lo = wr_fire && AVS_ADDRESS_IN == REG_MATCH_LO;
    wire wr_m_hi = wr_fire && AVS_ADDRESS_IN == REG_MATCH_HI;
    wire wr_c_lo = wr_fire && AVS_ADDRESS_IN == REG_CAP_LO;
    wire wr_c_hi = wr_fire && AVS_ADDRESS_IN == REG_CAP_HI;

    ////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge CLK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= CTRL_RST;
        end else if (STOP_ENTRY_IN) begin
            // Stop entry wins over a write in the same cycle
            ctrl_q.start <= START_STOP;
        end else if (wr_ctrl) begin
            ctrl_q <= wbyte[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Match and capture, staged through low byte then upper byte

    logic [7:0] m_lo_q;
    logic [CNT_W-1:0] m_stage_q;
    logic m_pend_q;
    logic [7:0] c_lo_q;
    logic [CNT_W-1:0] c_stage_q;
    logic c_pend_q;

    always_ff @(posedge CLK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            m_lo_q <= 8'h00;
            m_stage_q <= MATCH_RST;
            m_pend_q <= 1'b0;
            match_q <= MATCH_RST;
        end else begin
            if (wr_m_lo) begin
                m_lo_q <= wbyte;
            end
            if (wr_m_hi) begin
                m_stage_q <= {wbyte, m_lo_q};
                m_pend_q <= 1'b1;
            end else if (m_pend_q && src_tick) begin
                match_q <= m_stage_q;
                m_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            c_lo_q <= 8'h00;
            c_stage_q <= CAP_RST;
            c_pend_q <= 1'b0;
            cap_q <= CAP_RST;
        end else begin
            if (wr_c_lo) begin
                c_lo_q <= wbyte;
            end
            if (wr_c_hi) begin
                c_stage_q <= {wbyte, c_lo_q};
                c_pend_q <= 1'b1;
            end else if (c_pend_q && src_tick) begin
                c_pend_q <= 1'b0;
            end
            // Live capture overrides a staged software value
            if (auto_cap) begin
                cap_q <= cnt_q;
            end else if (c_pend_q && src_tick && !wr_c_hi) begin
                cap_q <= c_stage_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux

    assign rbyte =
        (AVS_ADDRESS_IN == REG_CTRL) ? {1'b0, ctrl_q} :
        (AVS_ADDRESS_IN == REG_MATCH_LO) ? match_q[7:0] :
        (AVS_ADDRESS_IN == REG_MATCH_HI) ? match_q[15:8] :
        (AVS_ADDRESS_IN == REG_CAP_LO) ? cap_q[7:0] :
        (AVS_ADDRESS_IN == REG_CAP_HI) ? cap_q[15:8] :
        (AVS_ADDRESS_IN == REG_CNT_LO) ? cnt_q[7:0] :
        (AVS_ADDRESS_IN == REG_CNT_HI) ? cnt_q[15:8] :
        {4'h0, pin_filt_q, c_pend_q, m_pend_q, run_q};

    always_ff @(posedge CLK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
            AVS_WAITREQUEST_OUT <= 1'b1;
            AVS_READDATA_OUT <= 32'h0000_0000;
        end else begin
            ack_q <= (AVS_READ_IN || AVS_WRITE_IN) && !ack_q;
            AVS_WAITREQUEST_OUT <= !((AVS_READ_IN || AVS_WRITE_IN) && !ack_q);
            if (AVS_READ_IN && !ack_q) begin
                AVS_READDATA_OUT <= {24'h000000, rbyte};
            end
        end
    end

endmodule

/* File: sim/mmuc_pulse_src.sv */
`timescale 1ns/1ps
module mmuc_pulse_src (
    input wire logic clk_in, // Bench clock
    output logic pin_out // Pulse pin
);
    initial pin_out = 1'b0;
    // A level lasts n+1 cycles; callers keep n at 11 or more, except noise
    task automatic level(input logic v, input int n);
        @(posedge clk_in);
        pin_out <= v;
        repeat (n) @(posedge clk_in);
    endtask
    task automatic pulse(input logic v, input int n);
        level(v, n);
        level(!v, 16);
    endtask
endmodule

/* File: sim/mmuc_chk.sv */
`timescale 1ns/1ps
module mmuc_chk
    import mmuc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic CLK_IN, // System clock
    input wire logic RST_N_IN, // Async reset
    input wire logic AVS_READ_IN, // Read request
    input wire logic AVS_WRITE_IN, // Write request
    input wire logic [31:0] AVS_READDATA_OUT, // Read data
    input wire logic AVS_WAITREQUEST_OUT, // Stall
    input wire logic STOP_ENTRY_IN, // Stop entry
    input wire logic MATCH_IRQ_OUT // Match pulse
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    ////////////////////////////////////////
    sequence s_answer;
        !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
    endsequence
    rd_answer_a: assert property (
        $rose(AVS_READ_IN) |-> AVS_WAITREQUEST_OUT ##1 s_answer)
        else $error("Read not answered after one cycle");
    wr_answer_a: assert property (
        $rose(AVS_WRITE_IN) |-> AVS_WAITREQUEST_OUT ##1 s_answer)
        else $error("Write not answered after one cycle");
    wait_idle_a: assert property (
        !(AVS_READ_IN || AVS_WRITE_IN) |-> AVS_WAITREQUEST_OUT)
        else $error("Waitrequest low without a request");
    wait_one_a: assert property (
        !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
        else $error("Waitrequest low for two cycles");
    rd_upper_a: assert property (
        AVS_READ_IN && !AVS_WAITREQUEST_OUT |-> AVS_READDATA_OUT[31:8] == 24'h0)
        else $error("Upper read data not zero");
    rd_hold_a: assert property (
        !AVS_READ_IN |=> $stable(AVS_READDATA_OUT))
        else $error("Read data changed without a read");
    irq_pulse_a: assert property (
        MATCH_IRQ_OUT |=> !MATCH_IRQ_OUT)
        else $error("Match pulse longer than one cycle");
    // A match in the entry cycle may still land one cycle later
    stop_quiet_a: assert property (
        STOP_ENTRY_IN |-> ##2 !MATCH_IRQ_OUT [*8])
        else $error("Match pulse after stop entry");
endmodule

bind mmuc_top mmuc_chk #(.CNT_W(CNT_W)) mmuc_chk_inst (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .AVS_READ_IN(AVS_READ_IN),
    .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
    .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .STOP_ENTRY_IN(STOP_ENTRY_IN),
    .MATCH_IRQ_OUT(MATCH_IRQ_OUT));

/* File: sim/test_mmuc_top.sv */
`timescale 1ns/1ps
module test_mmuc_top
    import mmuc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic low_spd = 1'b0;
    logic stop = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'h0;
    logic [31:0] rdata;
    logic wait_o;
    logic pin;
    logic irq;
    logic [7:0] q;
    logic [7:0] m;
    logic [7:0] cur = 8'h08;
    int num_errors = 0;
    int n_tests = 0;
    int nirq = 0;
    int cyc = 0;
    int last = 0;
    int gap = 0;
    int k;

    always #25 clk = ~clk;

    mmuc_top mmuc_top_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
        .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_o),
        .COUNTER_INPUT_PIN_IN(pin), .LOW_SPEED_IN(low_spd), .STOP_ENTRY_IN(stop),
        .MATCH_IRQ_OUT(irq));
    mmuc_pulse_src mmuc_pulse_src_inst (.clk_in(clk), .pin_out(pin));

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) begin
            gap <= cyc - last;
            last <= cyc;
            nirq <= nirq + 1;
        end
    end
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
            input logic [3:0] b);
        @(posedge clk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {24'h0, d};
        be <= b;
        // Only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge clk);
        end while (wait_o !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wr8(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask
    task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'h0);
        chk(q, e);
    endtask
    // Stop with the old fields, change fields while stopped, then start
    task automatic setmode(input logic [7:0] c);
        wr8(REG_CTRL, cur & 8'h4f);
        wr8(REG_CTRL, c & 8'h4f);
        wr8(REG_CTRL, c);
        cur = c;
        k = nirq;
    endtask
    task automatic lvl(input logic v, input int n);
        mmuc_pulse_src_inst.level(v, n);
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rdchk(i[2:0], (i == 1 || i == 2) ? 8'hff : 8'h00);
        end
        wr8(REG_CTRL, 8'h08);
        wr8(REG_MATCH_LO, 8'h03);
        repeat (20) @(posedge clk);
        rdchk(REG_MATCH_LO, 8'hff);
        wr8(REG_MATCH_HI, 8'h00);
        repeat (20) @(posedge clk);
        rdchk(REG_MATCH_LO, 8'h03);
        rdchk(REG_MATCH_HI, 8'h00);
        wr8(REG_CAP_LO, 8'h34);
        wr8(REG_CAP_HI, 8'h12);
        repeat (20) @(posedge clk);
        rdchk(REG_CAP_LO, 8'h34);
        rdchk(REG_CAP_HI, 8'h12);
        wr8(REG_CNT_LO, 8'h55);
        rdchk(REG_CNT_LO, 8'h00);
        bus(1'b1, REG_CTRL, 8'h18, 4'h0);
        rdchk(REG_CTRL, 8'h08);
        setmode(8'h18);
        while (nirq < k + 2) @(posedge clk);
        chk(gap[7:0], 8'h20);
        setmode(8'h14);
        while (nirq < k + 2) @(posedge clk);
        chk(gap[15:8], 8'h02);
        chk(gap[7:0], 8'h00);
        setmode(8'h58);
        repeat (10) @(posedge clk);
        m = 8'h00;
        repeat (6) begin
            rdchk(REG_CAP_HI, 8'h00);
            bus(1'b0, REG_CAP_LO, 8'h00, 4'h0);
            m = m | q;
        end
        chk(m, 8'h03);
        @(posedge clk);
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
        rdchk(REG_CTRL, 8'h48);
        setmode(8'h28);
        repeat (100) @(posedge clk);
        chk(nirq[7:0], k[7:0]);
        lvl(1'b1, 80);
        chk(nirq[7:0], 8'(k + 1));
        rdchk(REG_CNT_LO, 8'h00);
        lvl(1'b0, 20);
        lvl(1'b1, 20);
        lvl(1'b0, 60);
        chk(nirq[7:0], 8'(k + 2));
        setmode(8'h68);
        lvl(1'b1, 20);
        lvl(1'b0, 80);
        chk(nirq[7:0], k[7:0]);
        rdchk(REG_CNT_LO, 8'h00);
        setmode(8'h38);
        lvl(1'b1, 30);
        lvl(1'b0, 80);
        chk(nirq[7:0], 8'(k + 1));
        setmode(8'h2c);
        repeat (2) mmuc_pulse_src_inst.pulse(1'b1, 11);
        rdchk(REG_CNT_LO, 8'h02);
        lvl(1'b1, 30);
        chk(nirq[7:0], k[7:0]);
        lvl(1'b0, 30);
        chk(nirq[7:0], 8'(k + 1));
        mmuc_pulse_src_inst.pulse(1'b1, 3);
        rdchk(REG_CNT_LO, 8'h00);
        low_spd <= 1'b1;
        mmuc_pulse_src_inst.pulse(1'b1, 4);
        rdchk(REG_CNT_LO, 8'h01);
        low_spd <= 1'b0;
        setmode(8'h29);
        repeat (100) @(posedge clk);
        rdchk(REG_CNT_LO, 8'h00);
        lvl(1'b1, 60);
        chk(nirq[7:0], 8'(k + 1));
        setmode(8'h39);
        repeat (60) @(posedge clk);
        chk(nirq[7:0], k[7:0]);
        lvl(1'b0, 60);
        chk(nirq[7:0], 8'(k + 1));
        report_and_stop();
    end
endmodule
